/* logic/adc_serial_regs.vh */
// constants for the serial control port of the eight-channel converter:
// control byte fields, power mode codes and sequence counts.
// assumes inclusion by bare name from the design files.
`ifndef ADC_SERIAL_REGS_VH
`define ADC_SERIAL_REGS_VH

// ----------------------------------------------------------------
// control byte field positions (msb first on the wire)
// ----------------------------------------------------------------
`define CTL_START_BIT 7
`define CTL_SEL_HI 6
`define CTL_SEL_LO 4
`define CTL_POLARITY_BIT 3
`define CTL_CONFIG_BIT 2
`define CTL_PWR_HI 1
`define CTL_PWR_LO 0
`define CTL_WIDTH 8

// ----------------------------------------------------------------
// power mode codes
// ----------------------------------------------------------------
`define PWR_FULL_POWER_DOWN 2'h0
`define PWR_FAST_POWER_DOWN 2'h1
`define PWR_REDUCED_POWER 2'h2
`define PWR_NORMAL 2'h3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_CTL 8'h00
`define RST_DAC 12'h000
`define RST_CHANNEL 3'h0

// ----------------------------------------------------------------
// sequence counts, in serial-clock edges
// ----------------------------------------------------------------
// control bits received before tracking starts / hold begins
`define CNT_TRACK_BITS 4'h5
`define CNT_CTL_BITS 4'h8
// conversion step numbers, counted at rising edges after hold
`define STEP_STROBE 4'h2
`define STEP_FIRST 4'h3
`define STEP_LAST 4'he
`define STEP_TAIL 4'hf
// a new start bit is accepted once this step has been driven out
`define STEP_OVERLAP 4'h8
// successive-approximation word: ten result bits and two sub-lsb bits
`define SAR_WIDTH 12
`define SAR_FIRST_TRIAL 12'h800

`endif

/* logic/pin_sync.v */
// two-stage synchroniser for asynchronous pin levels.
// assumes the output is read only in the mclk domain.
`timescale 1ns/1ps

module pin_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   // clock and reset
   input wire mclk,
   input wire reset_n,
   // pin side and synchronised side
   input wire [WIDTH-1:0] pin_in,
   output reg [WIDTH-1:0] level_out
);

   reg [WIDTH-1:0] meta_r;

   // first stage is read by the second stage only
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         meta_r <= INIT;
         level_out <= INIT;
      end else begin
         meta_r <= pin_in;
         level_out <= meta_r;
      end
   end

endmodule

/* logic/adc_serial_control_port.v */
// serial control and sequencing of an eight-channel successive
// approximation converter: start bit search, control byte decode,
// track/hold timing, result framing and power mode handling.
// assumes a host master drives sclk, cs_n and din; the analog side
// supplies the comparator level and obeys the mux and dac outputs.
// Summary of operation
// - track/hold starts tracking at sclk fall after fifth control bit
// - track/hold enters hold at sclk fall after eighth control bit
// - single-ended uses common as negative; differential converts pair
// - at conversion end the positive input tracks the channel again
// - single-ended codes 0..7 select channels 0,2,4,6,1,3,5,7
// - differential codes pair even/odd channels, upper codes swap polarity
// - control byte: start, select 6..4, polarity, config, power 1..0
// - polarity bit one means unipolar, zero means bipolar
// - config bit one means single-ended, zero pseudo-differential
// - power field: 00 full down, 01 fast, 10 reduced, 11 normal
// - with cs low each sclk rise shifts one din bit in
// - leading zeros ignored; first one received is the start bit
// - result bytes: three zeros, result, two sub-lsb bits, one zero
// - strobe high one sclk period just before result msb
// - each conversion needs a control byte and takes 16 clocks
// - strobe and data out change only on sclk rising edges or at hardware shutdown
// - unipolar straight binary, bipolar two's complement, msb first
// - start bit also accepted after result bit 4 has been driven
// - data out and strobe go high impedance while cs is high
// - power modes apply after conversion; shutdown aborts at once
`timescale 1ns/1ps
`include "adc_serial_regs.vh"

module adc_serial_control_port (
   // clock and reset
   input wire mclk,
   input wire reset_n,
   // serial pins from the host
   input wire sclk,
   input wire cs_n,
   input wire din,
   // hardware shutdown pin
   input wire hardware_shutdown_n,
   // comparator decision from the analog core
   input wire comparator_hi,
   // serial pins to the host
   output reg dout,
   output reg dout_oe,
   output reg conversion_strobe,
   output reg conversion_strobe_oe,
   // track/hold and input multiplexer
   output reg hold_capacitor_track,
   output reg hold_capacitor_to_neg,
   output reg [2:0] pos_channel,
   output reg [2:0] neg_channel,
   output reg neg_is_common,
   output reg unipolar,
   // successive-approximation trial code
   output reg [11:0] dac_code,
   // power state
   output reg [1:0] power_mode,
   output reg shutdown_active,
   output reg converting
);

   // ----------------------------------------------------------------
   // state encodings
   // ----------------------------------------------------------------
   localparam [1:0] RX_IDLE = 2'b01;
   localparam [1:0] RX_CTL = 2'b10;
   localparam [1:0] CV_IDLE = 2'b01;
   localparam [1:0] CV_RUN = 2'b10;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   wire sclk_s;
   wire cs_n_s;
   wire din_s;
   wire shut_n_s;
   wire comp_s;

   pin_sync #(.WIDTH(5), .INIT(5'h0e)) u_sync (
      .mclk(mclk),
      .reset_n(reset_n),
      .pin_in({sclk, cs_n, din, hardware_shutdown_n, comparator_hi}),
      .level_out({sclk_s, cs_n_s, din_s, shut_n_s, comp_s})
   );

   reg sclk_d_r;
   wire sclk_rise = sclk_s & ~sclk_d_r;
   wire sclk_fall = ~sclk_s & sclk_d_r;

   // ----------------------------------------------------------------
   // state registers
   // ----------------------------------------------------------------
   reg [1:0] rx_state_r;
   reg [1:0] rx_state_nxt;
   reg [3:0] rx_cnt_r;
   reg [3:0] rx_cnt_nxt;
   reg [7:0] ctl_r;
   reg [7:0] ctl_nxt;
   reg [1:0] cv_state_r;
   reg [1:0] cv_state_nxt;
   reg [3:0] step_r;
   reg [3:0] step_nxt;
   reg [11:0] mask_r;
   reg [11:0] mask_nxt;
   reg [1:0] pend_pwr_r;
   reg [1:0] pend_pwr_nxt;
   reg bipolar_r;
   reg bipolar_nxt;

   // output next values
   reg dout_nxt;
   reg strobe_nxt;
   reg track_nxt;
   reg to_neg_nxt;
   reg [2:0] pos_nxt;
   reg [2:0] neg_nxt;
   reg neg_com_nxt;
   reg uni_nxt;
   reg [11:0] dac_nxt;
   reg [1:0] pwr_nxt;

   wire [3:0] step_inc = step_r + 4'h1;
   // sel bits sit at ctl_r[3:1] once five bits are in
   wire [2:0] sel_part = ctl_r[3:1];
   wire [2:0] sel_full = ctl_r[`CTL_SEL_HI:`CTL_SEL_LO];
   // overlap: a fresh start bit may arrive late in a conversion
   wire start_ok = (rx_state_r == RX_IDLE) &&
                   ((cv_state_r == CV_IDLE) ||
                    (step_r >= `STEP_OVERLAP));

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always @* begin
      rx_state_nxt = rx_state_r;
      rx_cnt_nxt = rx_cnt_r;
      ctl_nxt = ctl_r;
      cv_state_nxt = cv_state_r;
      step_nxt = step_r;
      mask_nxt = mask_r;
      pend_pwr_nxt = pend_pwr_r;
      bipolar_nxt = bipolar_r;
      dout_nxt = dout;
      strobe_nxt = conversion_strobe;
      track_nxt = hold_capacitor_track;
      to_neg_nxt = hold_capacitor_to_neg;
      pos_nxt = pos_channel;
      neg_nxt = neg_channel;
      neg_com_nxt = neg_is_common;
      uni_nxt = unipolar;
      dac_nxt = dac_code;
      pwr_nxt = power_mode;

      // conversion steps are paced by the serial clock itself
      if (sclk_rise && cv_state_r == CV_RUN) begin
         step_nxt = step_inc;
         strobe_nxt = (step_inc == `STEP_STROBE);
         dout_nxt = 1'b0;
         if (step_inc >= `STEP_FIRST && step_inc <= `STEP_LAST) begin
            // keep or drop the trial bit, then try the next lower one
            dac_nxt = (dac_code & ~mask_r) |
                      (comp_s ? mask_r : 12'h000) |
                      (mask_r >> 1);
            mask_nxt = mask_r >> 1;
            // two's complement in bipolar mode flips the msb
            if (mask_r == `SAR_FIRST_TRIAL && bipolar_r)
               dout_nxt = ~comp_s;
            else
               dout_nxt = comp_s;
         end
         if (step_inc == `STEP_TAIL) begin
            cv_state_nxt = CV_IDLE;
            step_nxt = 4'h0;
            track_nxt = 1'b1;
            to_neg_nxt = 1'b0;
            // a control byte already under way keeps full power
            if (rx_state_r == RX_IDLE)
               pwr_nxt = pend_pwr_r;
         end
      end

      // control byte reception
      if (sclk_rise && !cs_n_s) begin
         if (rx_state_r == RX_IDLE) begin
            if (din_s && start_ok) begin
               // zeros before the first one are simply dropped
               rx_state_nxt = RX_CTL;
               rx_cnt_nxt = 4'h1;
               ctl_nxt = 8'h01;
               pwr_nxt = `PWR_NORMAL;
            end
         end else if (rx_cnt_r < `CNT_CTL_BITS) begin
            ctl_nxt = {ctl_r[6:0], din_s};
            rx_cnt_nxt = rx_cnt_r + 4'h1;
         end
      end

      if (sclk_fall && rx_state_r == RX_CTL) begin
         if (rx_cnt_r == `CNT_TRACK_BITS) begin
            // positive channel is the select code rotated left by one
            pos_nxt = {sel_part[1], sel_part[0], sel_part[2]};
            track_nxt = 1'b1;
         end
         if (rx_cnt_r == `CNT_CTL_BITS) begin
            rx_state_nxt = RX_IDLE;
            rx_cnt_nxt = 4'h0;
            track_nxt = 1'b0;
            to_neg_nxt = 1'b1;
            cv_state_nxt = CV_RUN;
            step_nxt = 4'h0;
            mask_nxt = `SAR_FIRST_TRIAL;
            dac_nxt = `SAR_FIRST_TRIAL;
            uni_nxt = ctl_r[`CTL_POLARITY_BIT];
            bipolar_nxt = ~ctl_r[`CTL_POLARITY_BIT];
            pend_pwr_nxt = ctl_r[`CTL_PWR_HI:`CTL_PWR_LO];
            pos_nxt = {sel_full[1:0], sel_full[2]};
            if (ctl_r[`CTL_CONFIG_BIT]) begin
               neg_com_nxt = 1'b1;
               neg_nxt = `RST_CHANNEL;
            end else begin
               // odd partner of the pair; upper codes swap roles
               neg_com_nxt = 1'b0;
               neg_nxt = {sel_full[1], sel_full[0], ~sel_full[2]};
            end
         end
      end

      // hardware shutdown overrides sequencing, data out, strobe, track/hold and power at once
      if (!shut_n_s) begin
         rx_state_nxt = RX_IDLE;
         rx_cnt_nxt = 4'h0;
         cv_state_nxt = CV_IDLE;
         step_nxt = 4'h0;
         strobe_nxt = 1'b0;
         dout_nxt = 1'b0;
         track_nxt = 1'b1;
         to_neg_nxt = 1'b0;
         pwr_nxt = `PWR_FULL_POWER_DOWN;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sclk_d_r <= 1'b0;
         rx_state_r <= RX_IDLE;
         rx_cnt_r <= 4'h0;
         ctl_r <= `RST_CTL;
         cv_state_r <= CV_IDLE;
         step_r <= 4'h0;
         mask_r <= `RST_DAC;
         pend_pwr_r <= `PWR_NORMAL;
         bipolar_r <= 1'b0;
         dout <= 1'b0;
         conversion_strobe <= 1'b0;
         hold_capacitor_track <= 1'b1;
         hold_capacitor_to_neg <= 1'b0;
         pos_channel <= `RST_CHANNEL;
         neg_channel <= `RST_CHANNEL;
         neg_is_common <= 1'b1;
         unipolar <= 1'b1;
         dac_code <= `RST_DAC;
         power_mode <= `PWR_NORMAL;
      end else begin
         sclk_d_r <= sclk_s;
         rx_state_r <= rx_state_nxt;
         rx_cnt_r <= rx_cnt_nxt;
         ctl_r <= ctl_nxt;
         cv_state_r <= cv_state_nxt;
         step_r <= step_nxt;
         mask_r <= mask_nxt;
         pend_pwr_r <= pend_pwr_nxt;
         bipolar_r <= bipolar_nxt;
         dout <= dout_nxt;
         conversion_strobe <= strobe_nxt;
         hold_capacitor_track <= track_nxt;
         hold_capacitor_to_neg <= to_neg_nxt;
         pos_channel <= pos_nxt;
         neg_channel <= neg_nxt;
         neg_is_common <= neg_com_nxt;
         unipolar <= uni_nxt;
         dac_code <= dac_nxt;
         power_mode <= pwr_nxt;
      end
   end

   // ----------------------------------------------------------------
   // pin enables and status flags
   // ----------------------------------------------------------------
   // enables follow the synchronised chip select, so they lag the pin
   // by about three mclk periods
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         dout_oe <= 1'b0;
         conversion_strobe_oe <= 1'b0;
         shutdown_active <= 1'b0;
         converting <= 1'b0;
      end else begin
         dout_oe <= ~cs_n_s;
         conversion_strobe_oe <= ~cs_n_s;
         shutdown_active <= ~shut_n_s;
         converting <= (cv_state_nxt == CV_RUN);
      end
   end

endmodule

/* tb/adc_port_checker.sv */
// assertions on the converter serial port pins and state.
// assumes sclk levels of 5 mclk each, as the bench host drives them.
`timescale 1ns/1ps

module adc_port_checker (
   // clock and reset
   input wire mclk,
   input wire reset_n,
   // pins
   input wire sclk,
   input wire cs_n,
   input wire hardware_shutdown_n,
   input wire dout,
   input wire dout_oe,
   input wire conversion_strobe,
   input wire conversion_strobe_oe,
   // converter state
   input wire hold_capacitor_track,
   input wire hold_capacitor_to_neg,
   input wire [1:0] power_mode,
   input wire shutdown_active,
   input wire converting
);
   // a conversion spans 14.5 sclk periods, give or take the sync delay
   localparam int CONV_MIN = 140;
   localparam int CONV_MAX = 150;
   logic [7:0] conv_cnt_r;

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         conv_cnt_r <= 8'h00;
      else if (converting)
         conv_cnt_r <= conv_cnt_r + 8'h01;
      else
         conv_cnt_r <= 8'h00;
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);

   // outputs move 3 to 4 mclk after an sclk pin edge
   sequence after_rise;
      $past(sclk, 3) && !$past(sclk, 6);
   endsequence
   sequence after_fall;
      !$past(sclk, 3) && $past(sclk, 6);
   endsequence
   sequence strobe_high_span;
      conversion_strobe [*5] ##[1:8] !conversion_strobe;
   endsequence

   oe_cs_a: assert property ($stable(cs_n) [*4]
      |-> dout_oe == !cs_n && conversion_strobe_oe == !cs_n)
      else $error("output enable does not follow cs_n");
   strobe_len_a: assert property ($rose(conversion_strobe)
      |-> strobe_high_span) else $error("strobe not one sclk period");
   out_edge_a: assert property (
      ($changed(dout) || $changed(conversion_strobe)) && !shutdown_active
      |-> after_rise) else $error("output moved off an sclk rise");
   hold_fall_a: assert property (
      $fell(hold_capacitor_track) && !shutdown_active
      |-> (hold_capacitor_to_neg && converting) ##0 after_fall)
      else $error("hold not at the sclk fall");
   // in overlapped conversions tracking restarts while still converting
   track_start_a: assert property (
      $rose(hold_capacitor_track) && converting |-> after_fall)
      else $error("tracking not started at an sclk fall");
   end_track_a: assert property ($fell(converting)
      |-> hold_capacitor_track && !hold_capacitor_to_neg)
      else $error("input not tracking after conversion");
   conv_len_a: assert property (
      $fell(converting) && !shutdown_active
      |-> conv_cnt_r >= CONV_MIN && conv_cnt_r <= CONV_MAX)
      else $error("conversion length wrong");
   pwr_conv_a: assert property (
      converting |-> power_mode == 2'h3)
      else $error("power mode not normal while converting");
   hardware_shutdown_n_a: assert property (!hardware_shutdown_n [*4]
      |-> shutdown_active && !converting && power_mode == 2'h0)
      else $error("shutdown did not abort");
endmodule

bind adc_serial_control_port adc_port_checker adc_port_checker_i (
   .mclk(mclk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
   .hardware_shutdown_n(hardware_shutdown_n), .dout(dout),
   .dout_oe(dout_oe), .conversion_strobe(conversion_strobe),
   .conversion_strobe_oe(conversion_strobe_oe),
   .hold_capacitor_track(hold_capacitor_track),
   .hold_capacitor_to_neg(hold_capacitor_to_neg),
   .power_mode(power_mode), .shutdown_active(shutdown_active),
   .converting(converting)
);

/* tb/spi_host_model.sv */
// host serial master model: clock master, idle-low clock, data
// changed before each rise and sampled just before it.
// assumes frame is called at a falling mclk edge.
`timescale 1ns/1ps

module spi_host_model (
   // clock
   input wire mclk,
   // serial pins
   output logic sclk,
   output logic cs_n,
   output logic din,
   input wire dout,
   input wire conversion_strobe
);
   logic [47:0] rx;
   logic [47:0] sv;

   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din = 1'b1;
   end

   // n bits, tx left aligned; sclk stands low outside the frame
   task automatic frame(input int n, input logic [47:0] tx);
      int i;
      rx = 48'h0000_0000_0000;
      sv = 48'h0000_0000_0000;
      cs_n = 1'b0; // frame opens
      for (i = 0; i < n; i++) begin
         din = tx[47 - i]; // msb first, set while sclk low
         // 2.5 mhz keeps a 24-bit frame near 10 us
         repeat (5) @(negedge mclk);
         rx = {rx[46:0], dout};
         sv = {sv[46:0], conversion_strobe};
         sclk = 1'b1;
         repeat (5) @(negedge mclk);
         sclk = 1'b0;
      end
      repeat (5) @(negedge mclk);
      cs_n = 1'b1; // frame closes
      din = ~din;
   endtask
endmodule

/* tb/adc_serial_control_port_tb.sv */
// bench for the converter serial port: host frames, ideal analog side.
// assumes the checker is bound to the port module.
`timescale 1ns/1ps

module adc_serial_control_port_tb;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic hardware_shutdown_n = 1'b1;
   logic [11:0] vin = 12'h000;
   int n_errors = 0;
   int num_checks = 0;
   wire sclk, cs_n, din, dout, dout_oe, conversion_strobe, unipolar;
   wire conversion_strobe_oe, hold_capacitor_track, hold_capacitor_to_neg;
   wire neg_is_common, shutdown_active, converting;
   wire [2:0] pos_channel, neg_channel;
   wire [11:0] dac_code;
   wire [1:0] power_mode;
   // ideal comparator; undriven pins float so stale data is caught
   wire comparator_hi = (dac_code <= vin);
   wire dout_pin = dout_oe ? dout : 1'bz;
   wire strobe_pin = conversion_strobe_oe ? conversion_strobe : 1'bz;

   always #20 mclk = ~mclk;

   spi_host_model spi_host_model_i (
      .mclk(mclk), .sclk(sclk), .cs_n(cs_n), .din(din),
      .dout(dout_pin), .conversion_strobe(strobe_pin)
   );
   adc_serial_control_port adc_serial_control_port_i (
      .mclk(mclk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .din(din),
      .hardware_shutdown_n(hardware_shutdown_n),
      .comparator_hi(comparator_hi), .dout(dout), .dout_oe(dout_oe),
      .conversion_strobe(conversion_strobe),
      .conversion_strobe_oe(conversion_strobe_oe),
      .hold_capacitor_track(hold_capacitor_track),
      .hold_capacitor_to_neg(hold_capacitor_to_neg),
      .pos_channel(pos_channel), .neg_channel(neg_channel),
      .neg_is_common(neg_is_common), .unipolar(unipolar),
      .dac_code(dac_code), .power_mode(power_mode),
      .shutdown_active(shutdown_active), .converting(converting)
   );

   task automatic check(input string what, input logic [47:0] exp,
         input logic [47:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // result bytes: three zeros, msb inverted when bipolar, one tail zero
   function automatic logic [15:0] res(input logic [7:0] ctl);
      return {3'b000, vin[11] ^ ~ctl[3], vin[10:0], 1'b0};
   endfunction

   task automatic convert(input logic [7:0] ctl, input int z);
      logic [47:0] got;
      spi_host_model_i.frame(24 + z, {ctl, 40'h0} >> z);
      repeat (4) @(negedge mclk);
      check("result", 48'(res(ctl)), spi_host_model_i.rx);
      check("strobe", 48'h2000, spi_host_model_i.sv);
      check("pos", 48'({ctl[5:4], ctl[6]}), 48'(pos_channel));
      if (!ctl[2])
         check("neg", 48'({ctl[5:4], ~ctl[6]}), 48'(neg_channel));
      got = 48'({unipolar, neg_is_common, power_mode});
      check("mode", 48'(ctl[3:0]), got);
      check("oe", 48'h0, 48'({dout_oe, conversion_strobe_oe}));
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      int i;
      logic [47:0] got;
      repeat (8) @(negedge mclk);
      reset_n = 1'b1;
      repeat (8) @(negedge mclk);
      got = 48'({hold_capacitor_track, neg_is_common, unipolar, power_mode});
      check("reset", 48'h1f, got);
      $display("test reset done");
      for (i = 0; i < 16; i++) begin
         vin = 12'(i) * 12'h111;
         convert({1'b1, i[2:0], i[0] ^ i[3], i[3], i[1:0]}, i % 3);
      end
      $display("test decode done");
      vin = 12'h3c6;
      spi_host_model_i.frame(40, {8'hff, 8'h00, 8'hb7, 24'h0});
      got = {16'h0, res(8'hff), res(8'hb7)};
      check("overlap", got, spi_host_model_i.rx);
      check("ostrobe", 48'h2000_2000, spi_host_model_i.sv);
      $display("test overlap done");
      fork
         spi_host_model_i.frame(24, {8'hf3, 40'h0});
      join_none
      wait (converting === 1'b1);
      repeat (60) @(negedge mclk);
      hardware_shutdown_n = 1'b0;
      repeat (5) @(negedge mclk);
      got = 48'({converting, shutdown_active, power_mode});
      check("hardware_shutdown_n", 48'h4, got);
      wait (cs_n === 1'b1);
      @(negedge mclk);
      hardware_shutdown_n = 1'b1;
      repeat (10) @(negedge mclk);
      convert(8'h8f, 0);
      $display("test shutdown done");
      tally_and_finish;
   end

   // the tests take about 5100 mclk
   initial begin
      repeat (40000) @(posedge mclk);
      n_errors++;
      tally_and_finish;
   end
endmodule
